// >>> bench/audio_cmd_decoder_properties.sv
// assertion checker for the serial command decoder outputs
// assumes it is bound to the decoder top and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module audio_cmd_decoder_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic peak1_over_i,
  input wire logic peak2_over_i,
  input wire logic rx_audio_en_o,
  input wire logic mod_drive_en_o,
  input wire logic [3:0] input_level_o,
  input wire logic input_amp_en_o,
  input wire logic peak1_en_o,
  input wire logic peak2_en_o,
  input wire logic [4:0] mod1_level_o,
  input wire logic [4:0] mod2_level_o,
  input wire logic [7:0] volume_o,
  input wire logic auto_gain_sensor_o
);
  logic [3:0] idle_cnt_reg, idle_cnt_next;
  logic [2:0] run_cnt_reg, run_cnt_next;
  // settings may still land a few cycles after select rises
  always_comb begin
    idle_cnt_next = (idle_cnt_reg == 4'hF) ? 4'hF : idle_cnt_reg + 4'h1;
    if (!cs_n_i || sys_rst_i) idle_cnt_next = 4'h0;
    run_cnt_next = (run_cnt_reg == 3'h7) ? 3'h7 : run_cnt_reg + 3'h1;
    if (sys_rst_i) run_cnt_next = 3'h0;
  end
  always_ff @(posedge clk_i) begin
    idle_cnt_reg <= idle_cnt_next;
    run_cnt_reg <= run_cnt_next;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_amp_enable: assert property (
    input_amp_en_o == (input_level_o != 4'h0))
    else $error("amp enable disagrees with level");
  chk_sensor_follow: assert property (
    run_cnt_reg > 3'h4 |-> auto_gain_sensor_o ==
    (($past(peak1_over_i, 3) && $past(peak1_en_o)) ||
     ($past(peak2_over_i, 3) && $past(peak2_en_o))))
    else $error("sensor does not follow gated peaks");
  chk_sensor_hold: assert property (
    (peak2_over_i && peak2_en_o) [*4] |-> auto_gain_sensor_o)
    else $error("sensor low while peak persists");
  chk_sensor_quiet: assert property (
    (!peak1_en_o && !peak2_en_o) [*3] |=> !auto_gain_sensor_o)
    else $error("sensor high with detectors off");
  chk_ctl_idle: assert property (
    idle_cnt_reg > 4'h8 |->
    $stable({rx_audio_en_o, mod_drive_en_o, input_level_o}))
    else $error("control changed while bus idle");
  chk_mode_idle: assert property (
    idle_cnt_reg > 4'h8 |-> $stable({peak1_en_o, peak2_en_o, volume_o}))
    else $error("mode or volume changed while bus idle");
  chk_mod_idle: assert property (
    idle_cnt_reg > 4'h8 |-> $stable({mod1_level_o, mod2_level_o}))
    else $error("modulator level changed while bus idle");
  chk_reset_zero: assert property (
    $fell(sys_rst_i) |-> {rx_audio_en_o, input_level_o, peak1_en_o,
    volume_o, mod1_level_o, mod2_level_o} == 24'h0)
    else $error("settings not cleared by reset");
  cover property (auto_gain_sensor_o);
  cover property ($changed(volume_o));
  cover property ($changed(mod2_level_o));
endmodule
bind audio_cmd_decoder audio_cmd_decoder_checker i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
  .peak1_over_i(peak1_over_i), .peak2_over_i(peak2_over_i),
  .rx_audio_en_o(rx_audio_en_o), .mod_drive_en_o(mod_drive_en_o),
  .input_level_o(input_level_o), .input_amp_en_o(input_amp_en_o),
  .peak1_en_o(peak1_en_o), .peak2_en_o(peak2_en_o),
  .mod1_level_o(mod1_level_o), .mod2_level_o(mod2_level_o),
  .volume_o(volume_o), .auto_gain_sensor_o(auto_gain_sensor_o));
`default_nettype wire

// >>> bench/audio_cmd_decoder_tb.sv
// self-checking bench for the serial command decoder
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/100ps
`default_nettype none
module audio_cmd_decoder_tb;
  import audio_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic peak1 = 1'b0;
  logic peak2 = 1'b0;
  wire sclk, cs_n, sdata, amp_en, sensor;
  wire [7:0] ctl, mode, vol;
  wire [4:0] mod1, mod2;
  int err_count = 0;
  int compares = 0;
  // frame bytes, bit count, then control, mode, volume, mod1, mod2
  logic [71:0] steps [18] = '{
    72'h010000_08_00_00_00_00_00,
    72'h10A500_10_A5_00_00_00_00,
    72'h105A00_10_5A_00_00_00_00,
    72'h10F000_10_F0_00_00_00_00,
    72'h11C300_10_F0_C3_00_00_00,
    72'h113C00_10_F0_3C_00_00_00,
    72'h121F0A_18_F0_3C_00_1F_0A,
    72'h12FFE0_18_F0_3C_00_1F_00,
    72'h13A000_10_F0_3C_A0_1F_00,
    72'h121500_10_F0_3C_A0_1F_00,
    72'h103300_0C_F0_3C_A0_1F_00,
    72'h14FF00_10_F0_3C_A0_1F_00,
    72'h103377_18_33_3C_A0_1F_00,
    72'h01FF00_10_00_00_00_1F_00,
    72'h110400_10_00_04_00_1F_00,
    72'h121F1F_18_00_04_00_1F_1F,
    72'h100500_10_05_04_00_1F_1F,
    72'h113000_10_05_30_00_1F_1F};
  always #12.5 clk_i = ~clk_i;
  serial_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .data_o(sdata));
  audio_cmd_decoder i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .data_i(sdata), .peak1_over_i(peak1), .peak2_over_i(peak2),
    .rx_audio_en_o(ctl[7]), .mod_drive_en_o(ctl[6]),
    .pre_emph_en_o(ctl[5]), .mic_select_o(ctl[4]),
    .input_level_o(ctl[3:0]), .input_amp_en_o(amp_en),
    .cal_source_o(mode[7]), .dev_limiter_en_o(mode[6]),
    .peak2_en_o(mode[5]), .peak1_en_o(mode[4]),
    .ext_process_sel_o(mode[3]), .process_gain_o(mode[2:0]),
    .mod1_level_o(mod1), .mod2_level_o(mod2), .volume_o(vol),
    .auto_gain_sensor_o(sensor));
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_all(input logic [39:0] e);
    check(ctl, e[39:32]);
    check(mode, e[31:24]);
    check(vol, e[23:16]);
    check({3'h0, mod1}, e[15:8]);
    check({3'h0, mod2}, e[7:0]);
    check({7'h0, amp_en}, {7'h0, |e[35:32]});
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    // link side reset needs serial edges while reset is held
    fork
      i_host.idle(3);
      ticks(4);
    join
    ticks(1);
    sys_rst_i = 1'b0;
    // the link copy of reset lingers two serial edges after release
    i_host.idle(3);
    ticks(3);
    foreach (steps[i]) begin
      i_host.frame(steps[i][71:48], int'(steps[i][47:40]));
      i_host.idle(1);
      ticks(1);
      expect_all(steps[i][39:0]);
      $display("step %0d done", i);
    end
    peak1 = 1'b1;
    ticks(4);
    check({7'h0, sensor}, 8'h01);
    peak1 = 1'b0;
    peak2 = 1'b1;
    ticks(4);
    check({7'h0, sensor}, 8'h01);
    i_host.frame(24'h110000, 16);
    ticks(2);
    check({7'h0, sensor}, 8'h00);
    peak2 = 1'b0;
    $display("sensor test done");
    results();
  end
endmodule
`default_nettype wire

// >>> bench/serial_host_model.sv
// host model driving the serial command bus, 32 ns serial clock
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic data_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    data_o = 1'b1;
  end
  // edges with select high realign a receiver left by a cut byte
  task automatic idle(input int n);
    repeat (n) begin
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
  endtask
  // n bits of b from the top; a short n cuts the frame on purpose
  task automatic frame(input logic [23:0] b, input int n);
    cs_n_o = 1'b0;
    #16;
    for (int i = 0; i < n; i++) begin
      data_o = b[23 - i];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    data_o = ~data_o;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> rtl/audio_cmd_decoder.sv
// serial command decoder and setting latches of the audio processor
// assumes a host-driven serial clock that also runs outside frames and
// whole eight-bit bytes; a byte cut short by select leaves the bit
// counter misaligned until an idle serial clock edge realigns it
//
// Contract
// - decode headers 10h-13h and broadcast 01h
// - one data byte, two for modulator, none reset
// - first byte after select low is header
// - apply settings only after whole instruction
// - broadcast reset clears control, mode, volume
// - control bits 7-4 steer outputs and inputs
// - control bits 3-0 set input level
// - mode bits 7-4 steer source, limiter, detectors
// - enabled detector over threshold drives sensor high
// - bytes eight bits msb first on serial clock
// - mode low bits: input select, process gain
`timescale 1ns/100ps
`default_nettype none
module audio_cmd_decoder
  import audio_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic data_i,
  input wire logic peak1_over_i,
  input wire logic peak2_over_i,
  output logic rx_audio_en_o,
  output logic mod_drive_en_o,
  output logic pre_emph_en_o,
  output logic mic_select_o,
  output logic [3:0] input_level_o,
  output logic input_amp_en_o,
  output logic cal_source_o,
  output logic dev_limiter_en_o,
  output logic peak2_en_o,
  output logic peak1_en_o,
  output logic ext_process_sel_o,
  output logic [2:0] process_gain_o,
  output logic [4:0] mod1_level_o,
  output logic [4:0] mod2_level_o,
  output logic [7:0] volume_o,
  output logic auto_gain_sensor_o
);
  serial_byte_if link ();

  serial_byte_rx u_rx (
    .link_clk_i(sclk_i),
    .sys_rst_i(sys_rst_i),
    .cs_n_i(cs_n_i),
    .data_i(data_i),
    .out(link)
  );

  // synchronisers: the first stage of each is read only by the second
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_seen_reg;
  logic [1:0] peak_meta_reg;
  logic [1:0] peak_sync_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      peak_meta_reg <= 2'h0;
      peak_sync_reg <= 2'h0;
    end else begin
      cs_meta_reg <= cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      tgl_meta_reg <= link.byte_toggle;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_seen_reg <= tgl_sync_reg;
      peak_meta_reg <= {peak2_over_i, peak1_over_i};
      peak_sync_reg <= peak_meta_reg;
    end
  end

  // byte_data has been stable for several clk cycles when the toggle
  // edge is seen here, so it is read directly without a second copy
  logic byte_strobe;
  assign byte_strobe = tgl_sync_reg ^ tgl_seen_reg;

  decode_state_t state_reg;
  decode_state_t state_next;
  logic [7:0] hdr_reg;
  logic [7:0] hdr_next;
  logic [7:0] first_data_reg;
  logic [7:0] first_data_next;
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [4:0] mod1_reg;
  logic [4:0] mod1_next;
  logic [4:0] mod2_reg;
  logic [4:0] mod2_next;
  logic [7:0] volume_reg;
  logic [7:0] volume_next;
  logic sensor_reg;
  logic sensor_next;
  logic hdr_known;

  assign hdr_known = (link.byte_data == HDR_CONTROL) ||
                     (link.byte_data == HDR_MODE) ||
                     (link.byte_data == HDR_MOD_LEVELS) ||
                     (link.byte_data == HDR_VOLUME);

  always_comb begin
    state_next = state_reg;
    hdr_next = hdr_reg;
    first_data_next = first_data_reg;
    control_next = control_reg;
    mode_next = mode_reg;
    mod1_next = mod1_reg;
    mod2_next = mod2_reg;
    volume_next = volume_reg;
    if (byte_strobe) begin
      case (state_reg)
        ST_WAIT_HDR: begin
          // first byte of the frame is the header
          hdr_next = link.byte_data;
          if (link.byte_data == HDR_GENERAL_RESET) begin
            // no data follows; modulator levels are kept
            control_next = SETTING_RESET_VALUE;
            mode_next = SETTING_RESET_VALUE;
            volume_next = SETTING_RESET_VALUE;
            state_next = ST_IGNORE;
          end else if (hdr_known) begin
            state_next = ST_DATA_A;
          end else begin
            state_next = ST_IGNORE;
          end
        end
        ST_DATA_A: begin
          // single-byte commands apply here, modulator waits
          state_next = ST_IGNORE;
          case (hdr_reg)
            HDR_CONTROL: control_next = link.byte_data;
            HDR_MODE: mode_next = link.byte_data;
            HDR_VOLUME: volume_next = link.byte_data;
            HDR_MOD_LEVELS: begin
              first_data_next = link.byte_data;
              state_next = ST_DATA_B;
            end
            default: state_next = ST_IGNORE;
          endcase
        end
        ST_DATA_B: begin
          // both drives change together once the pair is in
          mod1_next = first_data_reg[MOD_LEVEL_MSB:MOD_LEVEL_LSB];
          mod2_next = link.byte_data[MOD_LEVEL_MSB:MOD_LEVEL_LSB];
          state_next = ST_IGNORE;
        end
        ST_IGNORE: state_next = ST_IGNORE; // excess bytes dropped
        default: state_next = ST_IGNORE;
      endcase
    end
    // select high ends the frame; partial data is dropped
    if (cs_sync_reg) begin
      state_next = ST_WAIT_HDR;
    end
  end

  // detector outputs are gated by their own enables
  always_comb begin
    sensor_next = (peak_sync_reg[0] & mode_reg[MODE_PEAK1_BIT]) |
                  (peak_sync_reg[1] & mode_reg[MODE_PEAK2_BIT]);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_WAIT_HDR;
      hdr_reg <= 8'h00;
      first_data_reg <= 8'h00;
      control_reg <= SETTING_RESET_VALUE;
      mode_reg <= SETTING_RESET_VALUE;
      mod1_reg <= MOD_LEVEL_RESET_VALUE;
      mod2_reg <= MOD_LEVEL_RESET_VALUE;
      volume_reg <= SETTING_RESET_VALUE;
      sensor_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hdr_reg <= hdr_next;
      first_data_reg <= first_data_next;
      control_reg <= control_next;
      mode_reg <= mode_next;
      mod1_reg <= mod1_next;
      mod2_reg <= mod2_next;
      volume_reg <= volume_next;
      sensor_reg <= sensor_next;
    end
  end

  assign rx_audio_en_o = control_reg[CTL_RX_AUDIO_BIT];
  assign mod_drive_en_o = control_reg[CTL_MOD_DRIVE_BIT];
  assign pre_emph_en_o = control_reg[CTL_PRE_EMPH_BIT];
  assign mic_select_o = control_reg[CTL_MIC_SEL_BIT];
  assign input_level_o = control_reg[CTL_LEVEL_MSB:CTL_LEVEL_LSB];
  // code 0 switches the amplifier off, 1..15 are gain steps
  assign input_amp_en_o =
    control_reg[CTL_LEVEL_MSB:CTL_LEVEL_LSB] != LEVEL_CODE_OFF;
  assign cal_source_o = mode_reg[MODE_CAL_BIT];
  assign dev_limiter_en_o = mode_reg[MODE_LIMITER_BIT];
  assign peak2_en_o = mode_reg[MODE_PEAK2_BIT];
  assign peak1_en_o = mode_reg[MODE_PEAK1_BIT];
  assign ext_process_sel_o = mode_reg[MODE_INSEL_BIT];
  assign process_gain_o = mode_reg[MODE_PGAIN_MSB:MODE_PGAIN_LSB];
  assign mod1_level_o = mod1_reg;
  assign mod2_level_o = mod2_reg;
  assign volume_o = volume_reg;
  assign auto_gain_sensor_o = sensor_reg;
endmodule
`default_nettype wire

// >>> rtl/audio_cmd_pkg.sv
// constants, field layout and decoder states for the serial command decoder
// assumes nothing beyond a SystemVerilog compiler
package audio_cmd_pkg;
  // header codes
  localparam logic [7:0] HDR_GENERAL_RESET = 8'h01;
  localparam logic [7:0] HDR_CONTROL = 8'h10;
  localparam logic [7:0] HDR_MODE = 8'h11;
  localparam logic [7:0] HDR_MOD_LEVELS = 8'h12;
  localparam logic [7:0] HDR_VOLUME = 8'h13;
  // value loaded by general reset and by system reset
  localparam logic [7:0] SETTING_RESET_VALUE = 8'h00;
  localparam logic [4:0] MOD_LEVEL_RESET_VALUE = 5'h00;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
  // control byte fields
  localparam int CTL_RX_AUDIO_BIT = 7;
  localparam int CTL_MOD_DRIVE_BIT = 6;
  localparam int CTL_PRE_EMPH_BIT = 5;
  localparam int CTL_MIC_SEL_BIT = 4;
  localparam int CTL_LEVEL_MSB = 3;
  localparam int CTL_LEVEL_LSB = 0;
  localparam logic [3:0] LEVEL_CODE_OFF = 4'h0;
  localparam logic [3:0] LEVEL_CODE_0DB = 4'h5;
  // mode byte fields
  localparam int MODE_CAL_BIT = 7;
  localparam int MODE_LIMITER_BIT = 6;
  localparam int MODE_PEAK2_BIT = 5;
  localparam int MODE_PEAK1_BIT = 4;
  localparam int MODE_INSEL_BIT = 3;
  localparam int MODE_PGAIN_MSB = 2;
  localparam int MODE_PGAIN_LSB = 0;
  localparam logic [2:0] PGAIN_CODE_0DB = 3'h4;
  // modulator level byte field
  localparam int MOD_LEVEL_MSB = 4;
  localparam int MOD_LEVEL_LSB = 0;

  typedef enum logic [1:0] {
    ST_WAIT_HDR = 2'b00,
    ST_DATA_A = 2'b01,
    ST_DATA_B = 2'b11,
    ST_IGNORE = 2'b10
  } decode_state_t;
endpackage

// >>> rtl/serial_byte_if.sv
// byte hand-over from the serial-clock receiver to the core decoder
// byte_data is stable for a whole byte time after each byte_toggle flip
`timescale 1ns/100ps
`default_nettype none
interface serial_byte_if;
  logic [7:0] byte_data;
  logic byte_toggle;
  modport producer (output byte_data, output byte_toggle);
  modport consumer (input byte_data, input byte_toggle);
endinterface
`default_nettype wire

// >>> rtl/serial_byte_rx.sv
// serial shift-in on the host serial clock, one toggle per whole byte
// assumes serial clock edges during system reset to clear the bit count
`timescale 1ns/100ps
`default_nettype none
module serial_byte_rx
  import audio_cmd_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic data_i,
  serial_byte_if.producer out
);
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [6:0] shift_reg;
  logic [6:0] shift_next;
  logic [7:0] byte_reg;
  logic [7:0] byte_next;
  logic toggle_reg;
  logic toggle_next;

  always_ff @(posedge link_clk_i) begin
    rst_meta_reg <= sys_rst_i;
    rst_sync_reg <= rst_meta_reg;
  end

  // bits arrive msb first on the rising serial clock
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_next = byte_reg;
    toggle_next = toggle_reg;
    if (rst_sync_reg) begin
      bit_cnt_next = 3'h0;
      shift_next = 7'h00;
      byte_next = 8'h00;
      toggle_next = 1'b0;
    end else if (cs_n_i) begin
      // an idle edge realigns the byte boundary
      bit_cnt_next = 3'h0;
    end else begin
      shift_next = {shift_reg[5:0], data_i};
      if (bit_cnt_reg == LAST_BIT_INDEX) begin
        byte_next = {shift_reg, data_i};
        toggle_next = ~toggle_reg;
        bit_cnt_next = 3'h0;
      end else begin
        bit_cnt_next = bit_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    bit_cnt_reg <= bit_cnt_next;
    shift_reg <= shift_next;
    byte_reg <= byte_next;
    toggle_reg <= toggle_next;
  end

  assign out.byte_data = byte_reg;
  assign out.byte_toggle = toggle_reg;
endmodule
`default_nettype wire
